//--- hw/cmb_store.sv
// Message buffer store with transmit selection and outgoing byte FIFO

// ********************************************************************
// Small FIFO between the buffer sequencer and the protocol engine
// ********************************************************************
module cmb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [PW:0]                 count;
    } cmb_fifo_st_t;

    cmb_fifo_st_t s;
    cmb_fifo_st_t next_s;
    logic         push;
    logic         pop;

    // Honest full and empty from the fill count
    assign in_ready  = (s.count != (PW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data  = s.mem[s.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wptr] = in_data;
            next_s.wptr = (s.wptr == PW'(DEPTH-1)) ? '0 : s.wptr + 1'b1;
        end
        if (pop)
            next_s.rptr = (s.rptr == PW'(DEPTH-1)) ? '0 : s.rptr + 1'b1;
        next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
        if (sys_rst)
        begin
            next_s.wptr  = '0;
            next_s.rptr  = '0;
            next_s.count = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s <= next_s;
    end
endmodule : cmb_fifo

// ********************************************************************
// Buffer store top
// ********************************************************************
module cmb_store (
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       cpu_sel,
    input  wire logic                       cpu_wr,
    input  wire logic [cmb_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic [7:0]                 cpu_wdata,
    output logic      [7:0]                 cpu_rdata,
    output logic                            ext_sel,
    input  wire logic [7:0]                 ext_rdata,
    input  wire logic [cmb_pkg::NUM_TX-1:0] tx_buffer_empty_flag,
    input  wire logic                       sof_req,
    output logic                            pick_valid,
    output logic                            pick_hit,
    output logic      [1:0]                 pick_buf,
    output logic                            tx_valid,
    input  wire logic                       tx_ready,
    output logic      [7:0]                 tx_byte,
    output logic                            tx_last,
    input  wire logic                       rx_valid,
    output logic                            rx_ready,
    input  wire logic                       rx_sof,
    input  wire logic [7:0]                 rx_byte
);
    import cmb_pkg::*;

    typedef struct packed {
        logic [NUM_BUF-1:0][BUF_BYTES-1:0][7:0] mem;
        logic [7:0]                             rdata;
        cmb_tx_state_t                          tx_st;
        logic [1:0]                             tx_buf;
        logic [3:0]                             tx_pos;
        logic [3:0]                             tx_len;
        logic                                   pick_valid;
        logic                                   pick_hit;
        logic [3:0]                             rx_pos;
        logic [3:0]                             rx_len;
    } cmb_st_t;

    cmb_st_t     s;
    cmb_st_t     next_s;
    cmb_region_t rgn;
    logic [1:0]  cpu_buf;
    logic [3:0]  cpu_ofs;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [8:0]  f_in_data;
    logic [3:0]  tx_ofs;
    logic [1:0]  win_buf;
    logic        win_hit;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Region of the 128-byte window
    function automatic cmb_region_t region(input logic [6:0] a);
        if (a <= CTRL_LAST)
            return RGN_CTRL;
        else if (a >= ERR_FIRST && a <= ERR_LAST)
            return RGN_ERR;
        else if (a >= FILT_FIRST && a <= FILT_LAST)
            return RGN_FILT;
        else if (a >= BUF_FIRST)
            return RGN_BUF;
        else
            return RGN_RSV;
    endfunction : region

    // Remote flag sits in byte 3 for extended, byte 1 for standard
    function automatic logic is_remote(input logic [7:0] id1,
                                       input logic [7:0] id3);
        return id1[BIT_FMT] ? id3[BIT_RTR_EXT] : id1[BIT_RTR_STD];
    endfunction : is_remote

    // Byte count from length code; remote frames carry none
    function automatic logic [3:0] byte_count(input logic [7:0] len,
                                              input logic       rtr);
        if (rtr)
            return 4'h0;
        else if (len[3:0] > MAX_COUNT)
            return MAX_COUNT;
        else
            return len[3:0];
    endfunction : byte_count

    // Buffer byte offset for a sequence step: ids, length, data
    function automatic logic [3:0] step_ofs(input logic [3:0] k);
        if (k <= OFS_ID3)
            return k;
        else if (k == SEQ_LEN_STEP)
            return OFS_LEN;
        else
            return k - 4'h1;
    endfunction : step_ofs

    // ****************************************************************
    // Address decode and transmit selection
    // ****************************************************************
    assign rgn     = region(cpu_addr);
    assign cpu_buf = cpu_addr[5:4];
    assign cpu_ofs = cpu_addr[3:0];
    assign ext_sel = cpu_sel && (rgn == RGN_CTRL || rgn == RGN_ERR
                                 || rgn == RGN_FILT);

    // Smallest priority among non-empty buffers, lower index on ties
    always_comb
    begin
        win_hit = 1'b0;
        win_buf = 2'h0;
        for (int i = 0; i < NUM_TX; i++)
        begin
            if (!tx_buffer_empty_flag[i])
            begin
                if (!win_hit || s.mem[i+1][OFS_PRIO] <
                                s.mem[win_buf+2'h1][OFS_PRIO])
                begin
                    win_hit = 1'b1;
                    win_buf = 2'(i);
                end
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    assign tx_ofs     = step_ofs(s.tx_pos);
    assign f_in_valid = (s.tx_st == TX_SEND);
    assign f_in_data  = {s.tx_pos == SEQ_LEN_STEP + s.tx_len,
                         s.mem[s.tx_buf + 2'h1][tx_ofs]};
    assign rx_ready   = 1'b1;

    always_comb
    begin
        next_s = s;
        next_s.pick_valid = 1'b0;
        // Processor read port, one cycle latency
        next_s.rdata = 8'h00;
        if (cpu_sel && !cpu_wr)
        begin
            if (rgn == RGN_BUF)
            begin
                if (cpu_ofs < OFS_PRIO
                    || (cpu_ofs == OFS_PRIO && cpu_buf != RX_BUF))
                    next_s.rdata = s.mem[cpu_buf][cpu_ofs];
            end
            else if (rgn != RGN_RSV)
                next_s.rdata = ext_rdata;
        end
        // Processor writes reach transmit buffers only
        if (cpu_sel && cpu_wr && rgn == RGN_BUF && cpu_buf != RX_BUF
            && cpu_ofs <= OFS_PRIO)
        begin
            if (cpu_ofs == OFS_LEN)
                next_s.mem[cpu_buf][cpu_ofs] = cpu_wdata & LEN_MASK;
            else
                next_s.mem[cpu_buf][cpu_ofs] = cpu_wdata;
        end
        // Receive fill from the protocol engine
        if (rx_valid)
        begin
            if (rx_sof)
                next_s.rx_pos = 4'h0;
            if (rx_sof || s.rx_pos <= SEQ_LEN_STEP)
            begin
                next_s.mem[RX_BUF][step_ofs(rx_sof ? 4'h0 : s.rx_pos)] =
                    (!rx_sof && s.rx_pos == SEQ_LEN_STEP)
                    ? (rx_byte & LEN_MASK) : rx_byte;
                if (!rx_sof && s.rx_pos == SEQ_LEN_STEP)
                    next_s.rx_len = byte_count(rx_byte,
                        is_remote(s.mem[RX_BUF][1], s.mem[RX_BUF][OFS_ID3]));
            end
            else if (s.rx_pos - SEQ_DATA0 < s.rx_len)
                next_s.mem[RX_BUF][step_ofs(s.rx_pos)] = rx_byte;
            if (rx_sof)
                next_s.rx_pos = 4'h1;
            else if (s.rx_pos != 4'hF)
                next_s.rx_pos = s.rx_pos + 4'h1;
        end
        // Transmit sequencer
        case (s.tx_st)
            TX_IDLE:
            begin
                if (sof_req)
                begin
                    next_s.pick_valid = 1'b1;
                    next_s.pick_hit   = win_hit;
                    next_s.tx_buf     = win_buf;
                    next_s.tx_pos     = 4'h0;
                    next_s.tx_len     = byte_count(
                        s.mem[win_buf + 2'h1][OFS_LEN],
                        is_remote(s.mem[win_buf + 2'h1][1],
                                  s.mem[win_buf + 2'h1][OFS_ID3]));
                    if (win_hit)
                        next_s.tx_st = TX_SEND;
                end
            end
            TX_SEND:
            begin
                if (f_in_ready)
                begin
                    next_s.tx_pos = s.tx_pos + 4'h1;
                    if (f_in_data[8])
                        next_s.tx_st = TX_IDLE;
                end
            end
            default:
                next_s.tx_st = TX_IDLE;
        endcase
        // Control state reset; message bytes are left undefined
        if (sys_rst)
        begin
            next_s.rdata      = 8'h00;
            next_s.tx_st      = TX_IDLE;
            next_s.tx_buf     = 2'h0;
            next_s.tx_pos     = 4'h0;
            next_s.tx_len     = 4'h0;
            next_s.pick_valid = 1'b0;
            next_s.pick_hit   = 1'b0;
            next_s.rx_pos     = 4'hF;
            next_s.rx_len     = 4'h0;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s <= next_s;
    end

    assign cpu_rdata  = s.rdata;
    assign pick_valid = s.pick_valid;
    assign pick_hit   = s.pick_hit;
    assign pick_buf   = s.tx_buf;

    // Outgoing byte stream; last flag marks the final byte
    cmb_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  ({tx_last, tx_byte})
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);


    // Receive buffer guard; offset 13 is never filled there
    chk_rx_no_write: assert property (
        cpu_sel && cpu_wr && cpu_addr[6:4] == 3'h4 && !rx_valid
        |=> $stable(s.mem[0][OFS_LEN:0]))
        else $error("receive buffer took a write");

    // Transmit selection, judged on contents at the start request
    chk_pick_nonempty: assert property (
        s.pick_valid && s.pick_hit
        |-> (($past(tx_buffer_empty_flag) >> s.tx_buf) & 3'h1) == 3'h0)
        else $error("empty buffer chosen");
    chk_pick_prio: assert property (
        sof_req && s.tx_st == TX_IDLE && !tx_buffer_empty_flag[0]
        && (tx_buffer_empty_flag[1]
            || s.mem[1][OFS_PRIO] <= s.mem[2][OFS_PRIO])
        && (tx_buffer_empty_flag[2]
            || s.mem[1][OFS_PRIO] <= s.mem[3][OFS_PRIO])
        |=> s.pick_hit && s.tx_buf == 2'h0)
        else $error("wrong buffer chosen");
    chk_pick_last: assert property (
        sof_req && s.tx_st == TX_IDLE && !tx_buffer_empty_flag[2]
        && (tx_buffer_empty_flag[0]
            || s.mem[3][OFS_PRIO] < s.mem[1][OFS_PRIO])
        && (tx_buffer_empty_flag[1]
            || s.mem[3][OFS_PRIO] < s.mem[2][OFS_PRIO])
        |=> s.pick_hit && s.tx_buf == 2'h2)
        else $error("last buffer not chosen");
    chk_sof_pick: assert property (
        sof_req && s.tx_st == TX_IDLE |=> s.pick_valid)
        else $error("no selection after start request");

    // Read port, stored length bits and outgoing frame
    chk_len_bound: assert property (
        s.tx_len <= MAX_COUNT) else $error("byte count above eight");
    chk_len_upper: assert property (
        cpu_sel && cpu_wr && cpu_addr[6] && cpu_ofs == OFS_LEN
        |=> s.mem[$past(cpu_buf)][OFS_LEN][7:4] == 4'h0)
        else $error("length upper bits stored");
    chk_unused_read: assert property (
        cpu_sel && !cpu_wr && cpu_addr[6] && cpu_addr[3:1] == 3'h7
        |=> cpu_rdata == 8'h00) else $error("unused byte not zero");
    chk_ext_region: assert property (
        ext_sel |-> cpu_addr < BUF_FIRST && cpu_addr != 7'h09)
        else $error("control strobe outside its region");
    chk_remote_empty: assert property (
        s.tx_st == TX_SEND && $past(s.tx_st) == TX_IDLE
        && is_remote(s.mem[s.tx_buf+1][1], s.mem[s.tx_buf+1][OFS_ID3])
        |-> s.tx_len == 4'h0) else $error("remote frame carries data");

    cov_pick: cover property (s.pick_valid && s.pick_hit);
    cov_none: cover property (s.pick_valid && !s.pick_hit);
    cov_full: cover property (f_in_valid && !f_in_ready);
    cov_rx:   cover property (rx_valid && s.rx_pos == 4'hC);
    cov_tie:  cover property (sof_req && s.tx_st == TX_IDLE
        && !tx_buffer_empty_flag[0] && !tx_buffer_empty_flag[1]
        && s.mem[1][OFS_PRIO] == s.mem[2][OFS_PRIO]);
endmodule : cmb_store

//--- hw/cmb_pkg.sv
// Constants and types shared by the CAN message buffer store
// How it works
// - Decode 128-byte window; control 0-8, error counters 14-15, filter 16-23.
// - Buffers at 0x40 receive, 0x50, 0x60, 0x70 transmit 0 to 2.
// - All buffers share one 16-byte outline holding a 13-byte message.
// - Bytes 0-3 identifier, 4-11 data, 12 length, 13 transmit priority.
// - Message contents are not reset and stay undefined after reset.
// - Receive buffer is read-only to the processor; transmit buffers read/write.
// - Identifiers are 11 or 29 bits; smaller value wins, MSB first.
// - Extended layout spreads ID28..ID0, substitute bit, format and remote flags.
// - Standard layout uses bytes 0 and 1 only; format flag zero.
// - Software sets substitute bit; receive stores it exactly as on the bus.
// - Format flag stored on receive; on transmit selects 29 or 11 bits.
// - Remote flag stored on receive; on transmit picks remote or data frame.
// - Length code in bits 3:0; codes 0 to 8 give byte count.
// - Remote transmit sends the programmed length code but no data bytes.
// - Eight data bytes per buffer; only the coded count is sent or filled.
// - Each transmit buffer has 8-bit local priority; smaller value wins.
// - Just before start of frame, every non-empty transmit buffer competes.
// - The candidate with the smallest priority value is chosen.
// - Equal smallest priorities resolve to the lowest buffer index.
package cmb_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam int            ADDR_W       = 7;
    localparam logic [6:0]    CTRL_LAST    = 7'h08;
    localparam logic [6:0]    ERR_FIRST    = 7'h0E;
    localparam logic [6:0]    ERR_LAST     = 7'h0F;
    localparam logic [6:0]    FILT_FIRST   = 7'h10;
    localparam logic [6:0]    FILT_LAST    = 7'h17;
    localparam logic [6:0]    BUF_FIRST    = 7'h40;
    localparam int            NUM_BUF      = 4;
    localparam int            NUM_TX       = 3;
    localparam logic [1:0]    RX_BUF       = 2'h0;

    // ****************************************************************
    // Buffer outline
    // ****************************************************************
    localparam int            BUF_BYTES    = 14;
    localparam logic [3:0]    OFS_ID3      = 4'h3;
    localparam logic [3:0]    OFS_DATA0    = 4'h4;
    localparam logic [3:0]    OFS_LEN      = 4'hC;
    localparam logic [3:0]    OFS_PRIO     = 4'hD;
    localparam logic [3:0]    MAX_COUNT    = 4'h8;
    localparam logic [7:0]    LEN_MASK     = 8'h0F;
    localparam int            BIT_FMT      = 3;
    localparam int            BIT_RTR_STD  = 4;
    localparam int            BIT_RTR_EXT  = 0;
    localparam logic [3:0]    SEQ_LEN_STEP = 4'h4;
    localparam logic [3:0]    SEQ_DATA0    = 4'h5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } cmb_tx_state_t;

    typedef enum logic [2:0] {
        RGN_CTRL, RGN_ERR, RGN_FILT, RGN_BUF, RGN_RSV
    } cmb_region_t;

endpackage : cmb_pkg

//--- tb/cmb_engine_model.sv
// Protocol engine stand-in that drains the outgoing byte stream
module cmb_engine_model (
    input  wire logic       ref_clk,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    int         frames = 0;
    logic [1:0] beat   = 2'h0;
    initial tx_ready = 1'b0;
    // Take bytes on ready; a slow engine stalls three cycles in four
    always @(posedge ref_clk)
    begin
        if (tx_valid && tx_ready)
        begin
            got.push_back(tx_byte);
            if (tx_last)
                frames++;
        end
        beat     <= beat + 2'h1;
        tx_ready <= !slow || (beat == 2'h3);
    end
endmodule : cmb_engine_model

//--- tb/cmb_store_test.sv
// Self-checking bench for the message buffer store
module cmb_store_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cmb_pkg::*;
    logic              ref_clk, sys_rst, cpu_sel, cpu_wr, ext_sel;
    logic [ADDR_W-1:0] cpu_addr;
    logic [7:0]        cpu_wdata, cpu_rdata, ext_rdata, tx_byte, rx_byte;
    logic [NUM_TX-1:0] tx_buffer_empty_flag;
    logic              sof_req, pick_valid, pick_hit, tx_valid, tx_ready;
    logic              tx_last, rx_valid, rx_ready, rx_sof, slow;
    logic [1:0]        pick_buf;
    logic [7:0]        r8;
    logic [7:0]        fr[$];
    logic [7:0]        exp_q[$];
    logic [31:0]       seed = 32'd40998;
    int                err_total = 0;
    int                comparisons = 0;
    int                mem[128];
    bit                known[128];
    int                best, base, f0;

    cmb_store DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .ext_sel(ext_sel),
        .ext_rdata(ext_rdata), .tx_buffer_empty_flag(tx_buffer_empty_flag),
        .sof_req(sof_req), .pick_valid(pick_valid), .pick_hit(pick_hit),
        .pick_buf(pick_buf), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_byte(tx_byte), .tx_last(tx_last), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_sof(rx_sof), .rx_byte(rx_byte));
    cmb_engine_model model (.ref_clk(ref_clk), .slow(slow),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .tx_last(tx_last));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // Bytes carried by a buffer: none for remote, codes above 8 give 8
    function automatic int cnt(input int b);
        if (mem[b+1][3] ? mem[b+3][0] : mem[b+1][4])
            return 0;
        return (mem[b+12] > 8) ? 8 : mem[b+12];
    endfunction : cnt

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_total++;
            $display("wrong value at %0t seen %0h expected %0h",
                $time, seen, want);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Processor write; only transmit bytes 0 to 13 are stored
    task automatic wr(input int a, input logic [7:0] d);
        @(negedge ref_clk);
        cpu_sel   = 1'b1;
        cpu_wr    = 1'b1;
        cpu_addr  = a[6:0];
        cpu_wdata = d;
        @(negedge ref_clk);
        cpu_sel = 1'b0;
        if (a >= 'h50 && a[3:0] < 14)
        begin
            mem[a]   = (a[3:0] == 12) ? (d & 8'h0F) : d;
            known[a] = 1'b1;
        end
    endtask : wr

    // Processor read compared with the map
    task automatic rd_chk(input int a);
        logic [7:0] e;
        bit         ext;
        ext = a <= 8 || a == 14 || a == 15 || (a >= 16 && a <= 23);
        e   = rnd();
        @(negedge ref_clk);
        cpu_sel   = 1'b1;
        cpu_wr    = 1'b0;
        cpu_addr  = a[6:0];
        ext_rdata = e;
        #1 chk(ext_sel, ext);
        @(negedge ref_clk);
        cpu_sel = 1'b0;
        if (ext)
            chk(cpu_rdata, e);
        else if (a < 'h40 || a[3:0] > 13 || (a < 'h50 && a[3:0] == 13))
            chk(cpu_rdata, 0);
        else if (known[a])
            chk(cpu_rdata, mem[a]);
    endtask : rd_chk

    // Engine hands a received frame to the receive buffer
    task automatic rx_frame();
        for (int i = 0; i < fr.size(); i++)
        begin
            @(negedge ref_clk);
            rx_valid = 1'b1;
            rx_sof   = (i == 0);
            rx_byte  = fr[i];
            if (i < 5)
                known['h40+((i < 4) ? i : 12)] = 1'b1;
            if (i < 4)
                mem['h40+i] = fr[i];
            else if (i == 4)
                mem['h4C] = fr[i] & 8'h0F;
            else if (i - 5 < cnt('h40))
            begin
                mem['h3F+i]   = fr[i];
                known['h3F+i] = 1'b1;
            end
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_byte  = ~rx_byte;
    endtask : rx_frame

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        {sys_rst, cpu_sel, cpu_wr, sof_req, rx_valid, rx_sof, slow} = 7'h40;
        {cpu_addr, cpu_wdata, ext_rdata, rx_byte} = '0;
        tx_buffer_empty_flag = 3'h7;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk({cpu_rdata, pick_valid, pick_hit, tx_valid}, 0);
        // Received frames: full, short with extra bytes, standard remote
        for (int k = 0; k < 3; k++)
        begin
            r8 = rnd();
            fr = {rnd(), (k == 2) ? ((r8 & 8'hE7) | 8'h10) : (r8 | 8'h08),
                rnd(), rnd() & 8'hFE, (k == 0) ? 8'h08 : 8'h03 + 2 * k};
            for (int i = 0; i < 8; i++)
                fr.push_back(rnd());
            rx_frame();
            for (int a = 'h40; a < 'h50; a++)
                rd_chk(a);
        end
        // Fill every buffer, gaps too, then read the whole window back
        for (int a = 'h40; a < 'h80; a++)
            wr(a, rnd());
        wr('h09, rnd());
        wr('h30, rnd());
        for (int a = 0; a < 'h80; a++)
            rd_chk(a);
        // Transmit selection and the outgoing byte order
        f0 = 0;
        for (int n = 0; n < 16; n++)
        begin
            for (int b = 'h50; b < 'h80; b += 'h10)
            begin
                wr(b + 1, rnd());
                wr(b + 3, rnd());
                wr(b + 12, rnd());
                wr(b + 13, rnd() & 8'h03);
            end
            r8 = rnd();
            @(negedge ref_clk);
            tx_buffer_empty_flag = (n == 5) ? 3'h7 : r8[2:0];
            slow    = n[0];
            sof_req = 1'b1;
            best    = -1;
            for (int b = 0; b < 3; b++)
                if (!r8[b] && n != 5 && (best < 0 ||
                    mem['h5D+16*b] < mem['h5D+16*best]))
                    best = b;
            @(negedge ref_clk);
            sof_req = 1'b0;
            chk(pick_valid, 1);
            chk(pick_hit, best >= 0);
            if (best >= 0)
            begin
                chk(pick_buf, best);
                base  = 'h50 + 16 * best;
                exp_q = {mem[base], mem[base+1], mem[base+2], mem[base+3],
                    mem[base+12]};
                for (int i = 0; i < cnt(base); i++)
                    exp_q.push_back(mem[base+4+i]);
            end
            else
                exp_q = {};
            for (int t = 0; t < 300 && model.frames == f0 && best >= 0; t++)
                @(negedge ref_clk);
            repeat (4) @(negedge ref_clk);
            f0 = model.frames;
            chk(model.got.size(), exp_q.size());
            foreach (exp_q[i])
                chk(model.got[i], exp_q[i]);
            model.got.delete();
        end
        tally_and_finish();
    end
endmodule : cmb_store_test
